//--- sim/conn_mode_checker.sv
`timescale 1ns/1ps
`default_nettype none
module conn_mode_checker
  import conn_mode_pkg::*;
#(parameter int SETTLE_CYCLES = 20) (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       power_good,
  input wire host_pins_t pins,
  input wire core_ctl_t  ctl,
  input wire logic       native_mode,
  input wire logic       legacy_mode,
  input wire logic       disabled,
  input wire logic       ready,
  input wire logic       card_det1_n,
  input wire logic       card_det2_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_card_gnd: assert property (!card_det1_n && !card_det2_n) else $error("card detect");
  a_quiet_settle: assert property (!ready |=> ctl == '0) else $error("ctl early");
  a_hold_off: assert property ($rose(power_good) |-> !ready [*8]) else $error("mode early");
  a_mode_due: assert property ($rose(power_good) |-> ##[1:40] ready) else $error("mode late");
  a_mode_pick: assert property ($rose(ready) |-> legacy_mode == $past(pins.sel_native_n)) else $error("mode");
  a_native_keep: assert property (native_mode && power_good && !pins.sel_native_n |=> native_mode) else $error("lost");
  a_dis_stick: assert property (disabled && power_good |=> disabled && ctl == '0) else $error("revived");
  a_native_mask: assert property (native_mode |=> !ctl.legacy_we && ctl.hi_addr == '0) else $error("legacy in");
  c_native: cover property ($rose(native_mode));
  c_legacy: cover property ($rose(legacy_mode));
  c_off: cover property ($rose(disabled));
endmodule
bind connector_mode_select conn_mode_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
  .clk        (clk),
  .arst_n     (arst_n),
  .power_good (power_good),
  .pins       (pins),
  .ctl        (ctl),
  .native_mode(native_mode),
  .legacy_mode(legacy_mode),
  .disabled   (disabled),
  .ready      (ready),
  .card_det1_n(card_det1_n),
  .card_det2_n(card_det2_n)
);
`default_nettype wire

//--- sim/connector_mode_select_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module connector_mode_select_tb_top;
  import conn_mode_pkg::*;
  localparam int SC = 20;
  logic       clk = 0, arst_n = 0, power_good = 0, split = 0;
  logic       core_dma_req = 0, core_not_ready = 0;
  logic       native_mode, legacy_mode, disabled, ready, dev_num;
  logic       card_det1_n, card_det2_n, dma_req, io_ready;
  host_pins_t cmd = '1, pins;
  core_ctl_t  ctl;
  int         num_errors = 0, samples_checked = 0, cycles = 0;
  initial forever #5 clk = ~clk;
  host_model hm (.cmd(cmd), .split(split), .pins(pins));
  connector_mode_select #(.SETTLE_CYCLES(SC)) dut (
    .clk           (clk),
    .arst_n        (arst_n),
    .power_good    (power_good),
    .pins          (pins),
    .core_dma_req  (core_dma_req),
    .core_not_ready(core_not_ready),
    .ctl           (ctl),
    .native_mode   (native_mode),
    .legacy_mode   (legacy_mode),
    .disabled      (disabled),
    .ready         (ready),
    .dev_num       (dev_num),
    .card_det1_n   (card_det1_n),
    .card_det2_n   (card_det2_n),
    .dma_req       (dma_req),
    .io_ready      (io_ready)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Power cycle; read strobe held active to prove the settle gate
  task automatic up(input logic s, input logic c);
    int n;
    n = 0;
    @(posedge clk);
    power_good <= 0;
    cmd.sel_native_n <= s;
    cmd.csel <= c;
    cmd.rd_n <= 0;
    @(posedge clk);
    power_good <= 1;
    do begin
      cyc(1);
      n++;
      if (n == 9) chk(ctl, 0);
    end while (ready !== 1'b1 && n < 99);
    chk(n >= SC && n <= SC + 3, 1);
    chk({native_mode, legacy_mode, dev_num}, {!s, s, c});
  endtask
  task automatic t_native;
    up(0, 1);
    @(posedge clk);
    cmd.cs1_pos_a_n <= 0;
    cmd.legacy_we_n <= 0;
    cmd.rst_n <= 0;
    cmd.cs0_n <= 0;
    cmd.dma_ack_n <= 0;
    cmd.addr <= 3'h5;
    split <= 1;
    core_dma_req <= 1;
    core_not_ready <= 1;
    cyc(2);
    chk({ctl.cs1, ctl.rst, native_mode}, 7);
    chk({ctl.hi_addr, ctl.legacy_we}, 0);
    chk({dma_req, io_ready, card_det1_n, card_det2_n}, 8);
    chk({ctl.cs0, ctl.rd, ctl.wr, ctl.dma_ack, ctl.addr}, 'h6D);
    @(posedge clk);
    cmd.sel_native_n <= 1;
    cyc(3);
    @(posedge clk);
    cmd.sel_native_n <= 0;
    cyc(2);
    chk({disabled, ctl}, 1 << 18);
    $display("test native done");
  endtask
  task automatic t_legacy;
    up(1, 0);
    cyc(2);
    chk({ctl.hi_addr, ctl.legacy_we, ctl.cs1}, 'h3FF);
    @(posedge clk);
    cmd.cs1_pos_a_n <= 1;
    cyc(2);
    chk(ctl.cs1, 0);
    $display("test legacy done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1;
    t_native;
    t_legacy;
    give_verdict;
  end
  // Run needs about 70 cycles; a stuck settle count is cut off by the 99-cycle bound in up, well before this limit
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      give_verdict;
    end
  end
endmodule
`default_nettype wire

//--- sim/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire conn_mode_pkg::host_pins_t cmd,
  input  wire logic                      split,
  output conn_mode_pkg::host_pins_t      pins
);
  // Split breaks the pin duplication on purpose
  always_comb begin
    pins = cmd;
    pins.cs1_pos_b_n = cmd.cs1_pos_a_n ^ split;
    pins.ms_n = ~cmd.csel;
  end
endmodule
`default_nettype wire

//--- verilog/conn_mode_pkg.sv
// Overview of operation
// [R1] Ignore host inputs for 19 ms after power
// [R2] Latch mode-select once; resets never resample
// [R3] Mode-select negated: legacy mode or go silent
// [R4] Host asserts mode-select before power, keeps it
// [R5] Both card-detect outputs driven to ground
// [R6] Host drives both chip-select-1 pins identically
// [R7] Decode chip select 1 from one pin
// [R8] DMA acknowledge and request come as pair
// [R9] Unsupported ready or DMA request held negated; io_ready is held high when HAS_IORDY is 0
// [R10] Device number from one selected input only
// [R11] Host sets cable-select lines before power
// [R12] Native mode ignores legacy address and write-enable
// [R13] Native mode passes full register interface signals
// [R14] Native mode, select lost: disable until power-off
// [R15] Chip selects, reset, mode-select default negated
// [R16] Host resets all devices on insertion change
// [R17] Host detects insertion to protect commands
// [R18] Settle counter on own clock from power-good
package conn_mode_pkg;

  localparam int  SETTLE_MS      = 19;
  localparam int  CLK_MHZ        = 100;
  localparam int  SETTLE_CYCLES  = SETTLE_MS * 1000 * CLK_MHZ * 1000 / 1000;
  localparam int  CNT_W          = 21;
  localparam int  ADDR_W         = 3;
  localparam int  HI_ADDR_W      = 8;

  typedef enum logic [1:0] {
    ST_SETTLE,
    ST_NATIVE,
    ST_LEGACY,
    ST_DISABLED
  } mode_state_t;

  // Host-facing control pins, all active low except csel and addresses
  typedef struct packed {
    logic              sel_native_n;
    logic              cs0_n;
    logic              cs1_pos_a_n;
    logic              cs1_pos_b_n;
    logic              rd_n;
    logic              wr_n;
    logic              rst_n;
    logic              dma_ack_n;
    logic              ms_n;
    logic              csel;
    logic              legacy_we_n;
    logic [ADDR_W-1:0]    addr;
    logic [HI_ADDR_W-1:0] hi_addr;
  } host_pins_t;

  // Qualified signals handed to the core
  typedef struct packed {
    logic              cs0;
    logic              cs1;
    logic              rd;
    logic              wr;
    logic              rst;
    logic              dma_ack;
    logic              legacy_we;
    logic [ADDR_W-1:0]    addr;
    logic [HI_ADDR_W-1:0] hi_addr;
  } core_ctl_t;

endpackage

//--- verilog/connector_mode_select.sv
`timescale 1ns/1ps
`default_nettype none
module connector_mode_select #(
  parameter int  SETTLE_CYCLES = conn_mode_pkg::SETTLE_CYCLES,
  parameter bit  CS1_USE_B     = 1'b0,
  parameter bit  USE_CSEL      = 1'b1,
  parameter bit  HAS_DMA       = 1'b1,
  parameter bit  HAS_IORDY     = 1'b1
) (
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire logic                      power_good,
  input  wire conn_mode_pkg::host_pins_t pins,
  input  wire logic                      core_dma_req,
  input  wire logic                      core_not_ready,
  output conn_mode_pkg::core_ctl_t       ctl,
  output logic                           native_mode,
  output logic                           legacy_mode,
  output logic                           disabled,
  output logic                           ready,
  output logic                           dev_num,
  output logic                           card_det1_n,
  output logic                           card_det2_n,
  output logic                           dma_req,
  output logic                           io_ready
);
  import conn_mode_pkg::*;

  typedef struct packed {
    mode_state_t st;
    core_ctl_t   ctl;
    logic        dev_num;
    logic        dma_req;
    logic        io_ready;
    // Mode flags kept as flops so every output leaves a register
    logic        native;
    logic        legacy;
    logic        dis;
    logic        rdy;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   settled;

  settle_timer #(
    .CYCLES(SETTLE_CYCLES)
  ) u_timer (
    .clk       (clk),
    .arst_n    (arst_n),
    .power_good(power_good),
    .done      (settled)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode decision and pin qualification

  always_comb begin
    logic cs1_raw;
    logic live;
    cs1_raw = CS1_USE_B ? pins.cs1_pos_b_n : pins.cs1_pos_a_n; // R7
    s_d     = s_q;
    live    = 1'b0;
    unique case (s_q.st)
      ST_SETTLE: begin
        // Mode pin sampled exactly once, at expiry of the settle count
        if (settled) begin
          if (!pins.sel_native_n) begin
            s_d.st = ST_NATIVE; // R2
          end else begin
            s_d.st = ST_LEGACY; // R3
          end
          s_d.dev_num = USE_CSEL ? pins.csel : !pins.ms_n; // R10
        end
      end
      ST_NATIVE: begin
        live = 1'b1;
        if (pins.sel_native_n) begin
          s_d.st = ST_DISABLED; // R14
          live   = 1'b0;
        end
      end
      ST_LEGACY: begin
        live = 1'b1;
      end
      ST_DISABLED: begin
        live = 1'b0; // R14
      end
    endcase
    // Loss of power drops back to settle, the only way out of disabled apart from arst_n
    if (!power_good) begin
      s_d.st = ST_SETTLE;
      live   = 1'b0;
    end
    // Every ctl signal defaults to negated so bouncing contacts select nothing
    s_d.ctl = '0; // R1 R15
    if (live) begin
      s_d.ctl.cs0     = !pins.cs0_n; // R13
      s_d.ctl.cs1     = !cs1_raw; // R7 R13
      s_d.ctl.rd      = !pins.rd_n; // R13
      s_d.ctl.wr      = !pins.wr_n; // R13
      s_d.ctl.rst     = !pins.rst_n; // R13
      s_d.ctl.addr    = pins.addr; // R13
      s_d.ctl.dma_ack = HAS_DMA && !pins.dma_ack_n; // R8
      if (s_q.st == ST_LEGACY) begin
        s_d.ctl.hi_addr   = pins.hi_addr;
        s_d.ctl.legacy_we = !pins.legacy_we_n;
      end // R12
    end
    s_d.dma_req  = HAS_DMA && live && core_dma_req; // R8 R9
    s_d.io_ready = !HAS_IORDY || !live || !core_not_ready; // R9
    s_d.native   = (s_d.st == ST_NATIVE);
    s_d.legacy   = (s_d.st == ST_LEGACY);
    s_d.dis      = (s_d.st == ST_DISABLED); // R14
    s_d.rdy      = s_d.native || s_d.legacy;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q          <= '0;
      s_q.st       <= ST_SETTLE;
      s_q.io_ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; card detects are a constant-low flop, never released

  logic cd_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cd_q <= 1'b0;
    end else begin
      cd_q <= 1'b0; // R5
    end
  end

  assign ctl         = s_q.ctl;
  assign native_mode = s_q.native;
  assign legacy_mode = s_q.legacy;
  assign disabled    = s_q.dis;
  assign ready       = s_q.rdy;
  assign dev_num     = s_q.dev_num;
  assign card_det1_n = cd_q;
  assign card_det2_n = cd_q;
  assign dma_req     = s_q.dma_req;
  assign io_ready    = s_q.io_ready;
endmodule
`default_nettype wire

//--- verilog/settle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module settle_timer #(
  parameter int CYCLES = conn_mode_pkg::SETTLE_CYCLES
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic power_good,
  output logic      done
);
  import conn_mode_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             done;
  } tmr_t;

  tmr_t s_q;
  tmr_t s_d;

  always_comb begin
    s_d = s_q;
    if (!power_good) begin
      s_d.cnt  = '0;
      s_d.done = 1'b0;
    end else if (!s_q.done) begin
      if (s_q.cnt == CNT_W'(CYCLES - 1)) begin
        s_d.done = 1'b1; // R18
      end else begin
        s_d.cnt = s_q.cnt + CNT_W'(1); // R18
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
endmodule
`default_nettype wire
